/* File: pfe_cfg.svh */
// Purpose: Named constants for the input filter and event detector block.
// Assumes: Included by bare name from every file that needs a constant.
// Notes: Only definitions live here; no logic.
`ifndef PFE_CFG_SVH
`define PFE_CFG_SVH

// ****************************************
// Line count and widths
// ****************************************
`define PFE_LINES 32
`define PFE_DIV_W 14

// ****************************************
// Reset values of the per-line state and the divider
// ****************************************
`define PFE_RST_LINES 32'h0000_0000
`define PFE_RST_DIV 14'h0000

// ****************************************
// Encodings of the per-line selector bits
// ****************************************
`define PFE_SEL_GLITCH 1'h0
`define PFE_SEL_DEBOUNCE 1'h1
`define PFE_EL_EDGE 1'h0
`define PFE_EL_LEVEL 1'h1
`define PFE_POL_FALL_LOW 1'h0
`define PFE_POL_RISE_HIGH 1'h1

// ****************************************
// Clock figures
// ****************************************
`define PFE_CLK_PERIOD_NS 4
`define PFE_DIV_MULT 2

`endif

/* File: pfe_event_port.sv */
// Purpose: Input conditioning and event detection for a 32-line port.
// Assumes: Pin inputs and the slow clock are synchronous to clock; control
//   strobes are one-cycle pulses whose set bits select the lines affected.
// Notes: Register outputs mirror the per-line state; status clears on read.
//
// Notes on behaviour
// RQ1: Glitch mode drops anything shorter than half a peripheral clock period.
// RQ2: Per-line select bit by set/clear strobes; 0 glitch, 1 debounce.
// RQ3: Debounce clock period is slow period times twice (divider plus one).
// RQ4: Filters reject pulses under half selected period, accept a full period.
// RQ5: Filter enable bit set by on strobe, cleared by off strobe.
// RQ6: Filtering affects only readback and change detection, not peripheral inputs.
// RQ7: Software keeps the peripheral clock running while filters are needed.
// RQ8: Change detection compares two successive peripheral-clock samples.
// RQ9: Irq mask bits set by on strobe, cleared by off strobe, readable.
// RQ10: Events are detected on every line whatever its pin configuration.
// RQ11: Without extra mode any edge either way is an event.
// RQ12: Extra mode bit set and cleared by strobes, readable.
// RQ13: Edge-or-level bit set by edge and level select strobes, readable.
// RQ14: Polarity bit picks falling/low or rising/high, readable.
// RQ15: Unwritten lines default to edge detection with falling/low polarity.
// RQ16: An event sets the status bit; irq asserts for a masked set bit.
// RQ17: Masked indications of all 32 lines are ORed into one request.
// RQ18: A status read clears all pending bits at once.
// RQ19: In level mode the status bit re-sets while the level persists.
// RQ20: Readback shows each line level, filtered where a filter is enabled.
// RQ21: An event in the cycle of a status read stays pending.
`timescale 1ns/1ns
`include "pfe_cfg.svh"

module pfe_event_port
  import pfe_pkg::*;
#(
  parameter int LINES = `PFE_LINES,
  parameter int DIV_W = `PFE_DIV_W
)
(
  input wire logic clock, // Peripheral clock, 250 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [LINES-1:0] pinIn, // Raw pad levels
  input wire logic slowClk, // Slow clock level, sampled
  input wire logic [LINES-1:0] filterSlowclkSelectSet, // Pick debounce
  input wire logic [LINES-1:0] filterSlowclkSelectClear, // Pick glitch
  input wire logic [LINES-1:0] inputFilterOn, // Enable filter
  input wire logic [LINES-1:0] inputFilterOff, // Disable filter
  input wire logic [LINES-1:0] eventIrqOn, // Unmask event
  input wire logic [LINES-1:0] eventIrqOff, // Mask event
  input wire logic [LINES-1:0] extraModeOn, // Enable extra mode
  input wire logic [LINES-1:0] extraModeOff, // Disable extra mode
  input wire logic [LINES-1:0] edgeDetectSelect, // Pick edge
  input wire logic [LINES-1:0] levelDetectSelect, // Pick level
  input wire logic [LINES-1:0] fallingLowSelect, // Pick falling/low
  input wire logic [LINES-1:0] risingHighSelect, // Pick rising/high
  input wire logic dividerWrite, // Load divider, pulse
  input wire logic [DIV_W-1:0] dividerValue, // Divider field
  input wire logic statusRead, // Status read, pulse
  output logic [LINES-1:0] filterSlowclkSelectStatus, // Select state
  output logic [LINES-1:0] inputFilterState, // Filter enable state
  output logic [LINES-1:0] eventIrqMask, // Irq mask state
  output logic [LINES-1:0] extraModeState, // Extra mode state
  output logic [LINES-1:0] edgeLevelState, // 1 means level
  output logic [LINES-1:0] polarityState, // 1 means rising/high
  output logic [DIV_W-1:0] debounceClockDividerReg, // Divider field
  output logic [LINES-1:0] pinLevelReadback, // Conditioned levels
  output logic [LINES-1:0] eventPendingStatus, // Pending events
  output logic [LINES-1:0] periphIn, // Unfiltered to peripherals
  output logic irq // Port interrupt request
);

  // ****************************************
  // Elaboration checks
  // ****************************************

  // The lines ride on a fixed-width package type
  if (LINES != `PFE_LINES) begin : g_bad_lines
    $error("LINES must equal the package line width");
  end
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must be between 1 and 16");
  end

  // ****************************************
  // Declarations
  // ****************************************
  pfe_lines_t pinSample_r;
  pfe_lines_t debounced;
  pfe_lines_t condLevel;
  pfe_lines_t prevLevel_r;
  pfe_lines_t eventHit;
  pfe_lines_t statusNxt;
  pfe_lines_t maskNxt;
  logic slckPrev_r;
  logic slckRise;
  logic [DIV_W-1:0] divCnt_r;
  logic divTick_r;
  logic divClk_r;

  // ****************************************
  // Per-line configuration state
  // ****************************************

  // Select bit: set picks the divided slow clock, set wins a clash
  always_ff @(posedge clock) begin
    if (!nrst) begin
      filterSlowclkSelectStatus <= `PFE_RST_LINES;
    end else begin
      filterSlowclkSelectStatus <= pfe_set_clear(filterSlowclkSelectStatus, filterSlowclkSelectSet,
                                                 filterSlowclkSelectClear); // RQ2
    end
  end

  // Filter enable bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      inputFilterState <= `PFE_RST_LINES;
    end else begin
      inputFilterState <= pfe_set_clear(inputFilterState, inputFilterOn, inputFilterOff); // RQ5
    end
  end

  // Interrupt mask, next value shared with the request logic
  assign maskNxt = pfe_set_clear(eventIrqMask, eventIrqOn, eventIrqOff); // RQ9

  always_ff @(posedge clock) begin
    if (!nrst) begin
      eventIrqMask <= `PFE_RST_LINES;
    end else begin
      eventIrqMask <= maskNxt; // RQ9
    end
  end

  // Extra mode bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      extraModeState <= `PFE_RST_LINES;
    end else begin
      extraModeState <= pfe_set_clear(extraModeState, extraModeOn, extraModeOff); // RQ12
    end
  end

  // Edge or level; reset to edge for lines never written
  always_ff @(posedge clock) begin
    if (!nrst) begin
      edgeLevelState <= `PFE_RST_LINES; // RQ15
    end else begin
      edgeLevelState <= pfe_set_clear(edgeLevelState, levelDetectSelect, edgeDetectSelect); // RQ13
    end
  end

  // Polarity; reset to falling/low for lines never written
  always_ff @(posedge clock) begin
    if (!nrst) begin
      polarityState <= `PFE_RST_LINES; // RQ15
    end else begin
      polarityState <= pfe_set_clear(polarityState, risingHighSelect, fallingLowSelect); // RQ14
    end
  end

  // Divider field
  always_ff @(posedge clock) begin
    if (!nrst) begin
      debounceClockDividerReg <= DIV_W'(`PFE_RST_DIV);
    end else if (dividerWrite) begin
      debounceClockDividerReg <= dividerValue;
    end
  end

  // ****************************************
  // Divided slow clock
  // ****************************************

  // The slow clock is a sampled level; its rising edge is one cycle wide
  always_ff @(posedge clock) begin
    if (!nrst) begin
      slckPrev_r <= 1'h0;
    end else begin
      slckPrev_r <= slowClk;
    end
  end

  assign slckRise = slowClk & ~slckPrev_r;

  // Tick every divider plus one slow edges: one half of the divided period,
  // so a full divided period is twice that
  always_ff @(posedge clock) begin
    if (!nrst) begin
      divCnt_r <= DIV_W'(`PFE_RST_DIV);
      divTick_r <= 1'h0;
    end else begin
      divTick_r <= 1'h0;
      if (slckRise) begin
        if (divCnt_r >= debounceClockDividerReg) begin
          divCnt_r <= DIV_W'(`PFE_RST_DIV); // RQ3
          divTick_r <= 1'h1; // RQ3
        end else begin
          divCnt_r <= divCnt_r + 1'h1;
        end
      end
    end
  end

  // Divided clock level, kept for visibility of the period
  always_ff @(posedge clock) begin
    if (!nrst) begin
      divClk_r <= 1'h0;
    end else if (divTick_r) begin
      divClk_r <= ~divClk_r; // RQ3
    end
  end

  // ****************************************
  // Input sampling and conditioning
  // ****************************************

  // Inputs are synchronous, so every change already lasts whole cycles and
  // nothing under half a clock period survives the sampling register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinSample_r <= `PFE_RST_LINES;
      periphIn <= `PFE_RST_LINES;
    end else begin
      pinSample_r <= pinIn; // RQ1
      periphIn <= pinIn; // RQ6
    end
  end

  // One debouncer per line on the shared tick
  for (genvar i = 0; i < LINES; i++) begin : g_deb
    pfe_line_filter u_filt (
      .clock(clock),
      .nrst(nrst),
      .sampleTick(divTick_r),
      .rawIn(pinSample_r[i]),
      .filtOut(debounced[i])
    );
  end

  // Per line: raw sample, or the chosen filter where one is enabled
  always_comb begin
    for (int j = 0; j < LINES; j++) begin
      if (inputFilterState[j] && filterSlowclkSelectStatus[j] == `PFE_SEL_DEBOUNCE) begin
        condLevel[j] = debounced[j]; // RQ4
      end else begin
        condLevel[j] = pinSample_r[j]; // RQ1
      end
    end
  end

  // Readback reflects every line whatever its pin role
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinLevelReadback <= `PFE_RST_LINES;
    end else begin
      pinLevelReadback <= condLevel; // RQ20
    end
  end

  // ****************************************
  // Event detection
  // ****************************************

  // Previous sample for change detection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prevLevel_r <= `PFE_RST_LINES;
    end else begin
      prevLevel_r <= pinLevelReadback; // RQ8
    end
  end

  // No gating on pin role: every line is watched
  always_comb begin // RQ10
    for (int k = 0; k < LINES; k++) begin
      if (!extraModeState[k]) begin
        eventHit[k] = pinLevelReadback[k] ^ prevLevel_r[k]; // RQ11
      end else if (edgeLevelState[k] == `PFE_EL_LEVEL) begin
        eventHit[k] = pinLevelReadback[k] == polarityState[k]; // RQ19
      end else if (polarityState[k] == `PFE_POL_RISE_HIGH) begin
        eventHit[k] = pinLevelReadback[k] & ~prevLevel_r[k]; // RQ14
      end else begin
        eventHit[k] = ~pinLevelReadback[k] & prevLevel_r[k]; // RQ14
      end
    end
  end

  // Read clears everything, but a same-cycle event survives
  assign statusNxt = (statusRead ? `PFE_RST_LINES : eventPendingStatus) | eventHit; // RQ18 RQ21

  always_ff @(posedge clock) begin
    if (!nrst) begin
      eventPendingStatus <= `PFE_RST_LINES;
    end else begin
      eventPendingStatus <= statusNxt; // RQ16
    end
  end

  // Request built from next values so it lines up with the status register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(statusNxt & maskNxt); // RQ17
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_edge_seen(int n);
    pinLevelReadback[n] != prevLevel_r[n];
  endsequence

  a_irq_or: assert property (irq == |(eventPendingStatus & eventIrqMask)) // RQ17
    else $error("interrupt does not match masked status");

  a_read_clear: assert property (statusRead && eventHit == `PFE_RST_LINES
    |=> eventPendingStatus == `PFE_RST_LINES) // RQ18
    else $error("status read did not clear");

  a_read_keeps: assert property (statusRead |=> (eventPendingStatus & $past(eventHit)) == $past(eventHit)) // RQ21
    else $error("event lost at status read");

  a_any_edge: assert property ((!extraModeState[0]) and s_edge_seen(0) |=> eventPendingStatus[0]) // RQ11
    else $error("any-edge event not flagged");

  // Level must still match in the read cycle itself; a level that drops
  // before the read legitimately lets the read clear the bit
  a_level_hold: assert property (statusRead && extraModeState[0] && edgeLevelState[0]
    && pinLevelReadback[0] == polarityState[0] |=> eventPendingStatus[0]) // RQ19
    else $error("level event not re-set after read");

  // Skipped on the first edge out of reset, where the register still holds 0
  a_unfilt_periph: assert property ($past(nrst) |-> periphIn == $past(pinIn)) // RQ6
    else $error("peripheral input not raw");

  a_filter_bit: assert property (inputFilterOn[0] |=> inputFilterState[0]) // RQ5
    else $error("filter enable did not set");

  a_mask_clear: assert property (eventIrqOff[0] && !eventIrqOn[0] |=> !eventIrqMask[0]) // RQ9
    else $error("mask clear ignored");

  a_sel_set: assert property (filterSlowclkSelectSet[0] |=> filterSlowclkSelectStatus[0]) // RQ2
    else $error("select set ignored");

  a_glitch_path: assert property (!inputFilterState[0] |=> pinLevelReadback[0] == $past(pinSample_r[0])) // RQ20
    else $error("readback not raw with filter off");

  a_tick_spacing: assert property (divTick_r |=> !divTick_r) // RQ3
    else $error("divider tick wider than one cycle");

  a_fall_edge: assert property (extraModeState[0] && !edgeLevelState[0] && !polarityState[0]
    && prevLevel_r[0] && !pinLevelReadback[0] |=> eventPendingStatus[0]) // RQ14
    else $error("falling edge not flagged");

endmodule

/* File: pfe_event_port_tb_top.sv */
// Purpose: Self-checking bench of the input filter and event port.
// Assumes: pfe_pin_model drives the pads and the slow clock.
// Notes: A cycle model is compared every cycle; debounce lines are checked apart.
`timescale 1ns/1ns
`include "pfe_cfg.svh"

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module pfe_event_port_tb_top
  import pfe_pkg::*;
;
  localparam int SLOW_HALF = 2;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic statusRead, dividerWrite, slowClk, irq, chkOn, mIrq;
  logic rbSeen, pfSeen, stSeen;
  logic [`PFE_DIV_W-1:0] dividerValue, divReg, mDiv;
  pfe_lines_t stb [12];
  pfe_lines_t st [6];
  pfe_lines_t mSt [6];
  pfe_lines_t pinIn, readback, status, periphIn, mS1, mLvl, mPrev, mStat, hit;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h1d63;

  // ****************************************
  // Clock, partner and design
  // ****************************************
  // Clock never stops, as both filters need it
  always #2 clock = ~clock;

  pfe_pin_model #(.SLOW_HALF(SLOW_HALF)) PINS (.clock(clock), .pinIn(pinIn), .slowClk(slowClk));

  pfe_event_port #(.LINES(`PFE_LINES), .DIV_W(`PFE_DIV_W)) DUT (
    .clock(clock), .nrst(nrst), .pinIn(pinIn), .slowClk(slowClk),
    .filterSlowclkSelectSet(stb[0]), .filterSlowclkSelectClear(stb[1]),
    .inputFilterOn(stb[2]), .inputFilterOff(stb[3]), .eventIrqOn(stb[4]), .eventIrqOff(stb[5]),
    .extraModeOn(stb[6]), .extraModeOff(stb[7]), .levelDetectSelect(stb[8]), .edgeDetectSelect(stb[9]),
    .risingHighSelect(stb[10]), .fallingLowSelect(stb[11]),
    .dividerWrite(dividerWrite), .dividerValue(dividerValue), .statusRead(statusRead),
    .filterSlowclkSelectStatus(st[0]), .inputFilterState(st[1]), .eventIrqMask(st[2]),
    .extraModeState(st[3]), .edgeLevelState(st[4]), .polarityState(st[5]),
    .debounceClockDividerReg(divReg), .pinLevelReadback(readback), .eventPendingStatus(status),
    .periphIn(periphIn), .irq(irq)
  );

  // ****************************************
  // Cycle model and comparison
  // ****************************************
  // Model steps on the old input values; outputs are compared once settled
  always @(posedge clock) begin
    if (!nrst) begin
      for (int k = 0; k < 6; k++) begin
        mSt[k] = '0;
      end
      {mS1, mLvl, mPrev, mStat, mDiv} = '0;
    end else begin
      hit = (~mSt[3] & (mLvl ^ mPrev))
        | (mSt[3] & mSt[4] & ~(mLvl ^ mSt[5]))
        | (mSt[3] & ~mSt[4] & (mLvl ^ mPrev) & ~(mLvl ^ mSt[5]));
      mStat = (statusRead ? '0 : mStat) | hit;
      mPrev = mLvl;
      mLvl = mS1;
      mS1 = pinIn;
      for (int k = 0; k < 6; k++) begin
        mSt[k] = (mSt[k] & ~stb[2 * k + 1]) | stb[2 * k];
      end
      if (dividerWrite) begin
        mDiv = dividerValue;
      end
    end
    mIrq = |(mStat & mSt[2]);
    #1;
    if (chkOn) begin
      for (int k = 0; k < 6; k++) begin
        `CHK("state", mSt[k], st[k])
      end
      `CHK("divider", mDiv, divReg)
      `CHK("periph", mS1, periphIn)
      `CHK("readback", mLvl, readback)
      `CHK("status", mStat, status)
      `CHK("irq", mIrq, irq)
    end
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  // Sparse random strobes; debounce select stays off so the model holds exactly
  task automatic rand_cycle();
    @(posedge clock);
    for (int k = 1; k < 12; k++) begin
      stb[k] <= $random(seed) & $random(seed) & $random(seed);
    end
    statusRead <= 1'($random(seed)) & 1'($random(seed));
    dividerWrite <= 1'($random(seed));
    dividerValue <= 14'($random(seed));
    PINS.set_pins(pinIn ^ ($random(seed) & $random(seed)));
  endtask

  // Idle cycles that gather what line 0 showed
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      for (int k = 0; k < 12; k++) begin
        stb[k] <= '0;
      end
      statusRead <= 1'b0;
      dividerWrite <= 1'b0;
      #1;
      rbSeen |= readback[0];
      pfSeen |= periphIn[0];
      stSeen |= status[0];
    end
  endtask

  // Line 0 on debounce: short pulse dropped, long pulse kept
  task automatic deb(input int div);
    int t;
    t = (div + 1) * 2 * SLOW_HALF;
    @(posedge clock);
    PINS.set_pins('0);
    quiet(1);
    @(posedge clock);
    stb[0] <= 32'h1;
    stb[2] <= 32'h1;
    stb[4] <= 32'h1;
    stb[7] <= 32'h1;
    dividerWrite <= 1'b1;
    dividerValue <= 14'(div);
    quiet(40);
    `CHK("divider", 14'(div), divReg)
    @(posedge clock);
    statusRead <= 1'b1;
    quiet(1);
    {rbSeen, pfSeen, stSeen} = '0;
    @(posedge clock);
    PINS.set_pins(32'h1);
    quiet(t / 2);
    @(posedge clock);
    PINS.set_pins(32'h0);
    quiet(2 * t);
    `CHK("short periph", 1'b1, pfSeen)
    `CHK("short readback", 1'b0, rbSeen)
    `CHK("short status", 1'b0, stSeen)
    @(posedge clock);
    PINS.set_pins(32'h1);
    quiet(3 * t);
    `CHK("long readback", 1'b1, readback[0])
    `CHK("long status", 1'b1, stSeen)
    @(posedge clock);
    PINS.set_pins(32'h0);
    quiet(3 * t);
    `CHK("release readback", 1'b0, readback[0])
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is near 1040 cycles, so this only fires on a hang
  initial begin
    #20000;
    error_cnt++;
    $display("[FAIL] watchdog exp done got hang");
    stop_test();
  end

  initial begin
    for (int k = 0; k < 12; k++) begin
      stb[k] = '0;
    end
    {statusRead, dividerWrite, dividerValue, chkOn} = '0;
    {rbSeen, pfSeen, stSeen} = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    chkOn = 1'b1;
    repeat (400) rand_cycle();
    $display("Test random_events done");
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (400) rand_cycle();
    $display("Test reset_rerun done");
    chkOn = 1'b0;
    deb(0);
    deb(2);
    $display("Test debounce done");
    stop_test();
  end
endmodule

/* File: pfe_line_filter.sv */
// Purpose: One-line debouncing filter sampled on divided slow clock ticks.
// Assumes: sampleTick pulses once per half period of the divided slow clock.
// Notes: Output follows the input only when two successive samples agree.
`timescale 1ns/1ns
`include "pfe_cfg.svh"

module pfe_line_filter
  import pfe_pkg::*;
(
  input wire logic clock, // Peripheral clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic sampleTick, // Half-period tick of divided slow clock
  input wire logic rawIn, // Synchronous sampled line level
  output logic filtOut // Debounced level
);

  logic lastSample_r;

  // ****************************************
  // Sample store and acceptance
  // ****************************************

  // A pulse under half a divided period holds at most one sample point,
  // so it never meets an agreeing pair and is dropped
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lastSample_r <= 1'h0;
    end else if (sampleTick) begin
      lastSample_r <= rawIn;
    end
  end

  // Accept on agreement; a full divided period spans two sample points
  always_ff @(posedge clock) begin
    if (!nrst) begin
      filtOut <= 1'h0; // RQ4
    end else if (sampleTick && (rawIn == lastSample_r)) begin
      filtOut <= rawIn; // RQ4
    end
  end

  a_filter_hold: assert property (@(posedge clock) disable iff (!nrst)
    !sampleTick |=> $stable(filtOut)) // RQ4
    else $error("debounced level moved without a tick");

endmodule

/* File: pfe_pin_model.sv */
// Purpose: Far-side model of the port: pad levels and a free-running slow clock.
// Assumes: The bench calls set_pins just after a rising edge of clock.
// Notes: The slow clock is derived from clock so every one of its edges is sampled.
`timescale 1ns/1ns

module pfe_pin_model
  import pfe_pkg::*;
#(
  parameter int SLOW_HALF = 2
)
(
  input wire logic clock, // Peripheral clock
  output pfe_lines_t pinIn, // Pad levels
  output logic slowClk // Slow clock level
);
  int halfCnt = 0;

  // ****************************************
  // Slow clock
  // ****************************************
  // Runs free, since the real oscillator never pauses between pulses
  initial begin
    pinIn = '0;
    slowClk = 1'b0;
  end
  always @(posedge clock) begin
    halfCnt <= (halfCnt == SLOW_HALF - 1) ? 0 : halfCnt + 1;
    if (halfCnt == SLOW_HALF - 1) begin
      slowClk <= ~slowClk;
    end
  end

  // ****************************************
  // Pads
  // ****************************************
  // Pads are synchronous here, so no sub-cycle glitch ever reaches the port
  task automatic set_pins(input pfe_lines_t v);
    pinIn <= v;
  endtask
endmodule

/* File: pfe_pkg.sv */
// Purpose: Types and shared helpers of the input filter and event block.
// Assumes: pfe_cfg.svh is on the include path.
// Notes: The set/clear helper lets a set win over a clear in the same cycle.
`include "pfe_cfg.svh"

package pfe_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [`PFE_LINES-1:0] pfe_lines_t;

  // Per-line state held by a pair of set and clear strobes
  function automatic pfe_lines_t pfe_set_clear(input pfe_lines_t cur, input pfe_lines_t setV,
                                               input pfe_lines_t clrV);
    pfe_set_clear = (cur & ~clrV) | setV;
  endfunction

endpackage
